// file: verilog/spm_top.sv
// Top of the serial port pin mux: registers, ball selection and pull controls.
//
// Contract
// [RULE1] Transmit reaches its ball only when mux nine bits 23:21 hold 001.
// [RULE2] Receive is connected to its ball from reset, no write needed.
// [RULE3] Clear-to-send is connected to its ball from reset, no write needed.
// [RULE4] Request-to-send reaches its ball only when mux nine bits 14:12 hold 001.
// [RULE5] Terminal-ready: ball A via mux eight 5:3=010, ball B via mux ten 2:0=010.
// [RULE6] Set-ready: ball A via mux eight 2:0=010, ball B via mux nine 29:27=010.
// [RULE7] After reset muxed signals stay off their balls until software selects them.
// [RULE8] Software enables pull-up or pull-down per capable pin.
// [RULE9] A ball may select among up to five peripheral signals.
// [RULE10] Each ball has one source; unassigned codes keep the default function. Here only codes 5 to 7 do; empty slots below 5 float the ball.
module spm_top (
   // Clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   // Register port
   input  wire logic [3:0]                    reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic [31:0]                        reg_rdata,
   // Serial port side
   input  wire logic                          serial_port_one_transmit,
   input  wire logic                          serial_port_one_request_to_send,
   input  wire logic                          serial_port_one_terminal_ready,
   input  wire logic                          serial_port_one_set_ready,
   output logic                               serial_port_one_receive,
   output logic                               serial_port_one_clear_to_send,
   // Default functions of the muxed balls and their alternates
   input  wire logic [spm_pkg::SPM_NBALL-1:0] dflt_out,
   input  wire logic [spm_pkg::SPM_NBALL-1:0] dflt_oe_n,
   input  wire logic [spm_pkg::SPM_NBALL-1:0] alt_out,
   // Balls
   input  wire logic                          rx_ball_in,
   input  wire logic                          cts_ball_in,
   output logic [spm_pkg::SPM_NBALL-1:0]      ball_out,
   output logic [spm_pkg::SPM_NBALL-1:0]      ball_oe_n,
   output logic [spm_pkg::SPM_NBALL-1:0]      ball_pull_up_en,
   output logic [spm_pkg::SPM_NBALL-1:0]      ball_pull_down_en
);

   import spm_pkg::*;

   spm_req_t    req;
   logic [31:0] mux8_r;
   logic [31:0] mux9_r;
   logic [31:0] mux10_r;
   logic [31:0] pulldn_r;
   logic [31:0] pullen_r;
   logic [1:0]  rx_sync_r;
   logic [1:0]  cts_sync_r;
   logic [31:0] rdata_nxt;
   logic [2:0]  sel [SPM_NBALL];
   logic [SPM_NBALL-1:0] pu_nxt;
   logic [SPM_NBALL-1:0] pd_nxt;
   logic [SPM_NBALL-1:0] status_w;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // [RULE1] Transmit select field
   assign sel[SPM_BALL_TX] = mux9_r[SPM_TX_LSB +: 3];
   // [RULE4] Request-to-send select field
   assign sel[SPM_BALL_RTS] = mux9_r[SPM_RTS_LSB +: 3];
   // [RULE5] Terminal-ready select fields
   assign sel[SPM_BALL_DTR_A] = mux8_r[SPM_DTR_A_LSB +: 3];
   assign sel[SPM_BALL_DTR_B] = mux10_r[SPM_DTR_B_LSB +: 3];
   // [RULE6] Set-ready select fields
   assign sel[SPM_BALL_DSR_A] = mux8_r[SPM_DSR_A_LSB +: 3];
   assign sel[SPM_BALL_DSR_B] = mux9_r[SPM_DSR_B_LSB +: 3];

   // Source lists per ball; slot 0 is the ball's default function.
   spm_src_t src [SPM_NBALL];

   // [RULE1] Transmit on code 001
   assign src[SPM_BALL_TX] = '{out:  {alt_out[0], 1'h0, 1'h0, serial_port_one_transmit, dflt_out[0]},
                               oe_n: {1'h0, 1'h1, 1'h1, 1'h0, dflt_oe_n[0]}};
   // [RULE4] Request-to-send on code 001
   assign src[SPM_BALL_RTS] = '{out:  {alt_out[1], 1'h0, 1'h0, serial_port_one_request_to_send, dflt_out[1]},
                                oe_n: {1'h0, 1'h1, 1'h1, 1'h0, dflt_oe_n[1]}};
   // [RULE5] Terminal-ready on code 010
   assign src[SPM_BALL_DTR_A] = '{out:  {alt_out[2], 1'h0, serial_port_one_terminal_ready, 1'h0, dflt_out[2]},
                                  oe_n: {1'h0, 1'h1, 1'h0, 1'h1, dflt_oe_n[2]}};
   assign src[SPM_BALL_DTR_B] = '{out:  {alt_out[3], 1'h0, serial_port_one_terminal_ready, 1'h0, dflt_out[3]},
                                  oe_n: {1'h0, 1'h1, 1'h0, 1'h1, dflt_oe_n[3]}};
   // [RULE6] Set-ready on code 010
   assign src[SPM_BALL_DSR_A] = '{out:  {alt_out[4], 1'h0, serial_port_one_set_ready, 1'h0, dflt_out[4]},
                                  oe_n: {1'h0, 1'h1, 1'h0, 1'h1, dflt_oe_n[4]}};
   assign src[SPM_BALL_DSR_B] = '{out:  {alt_out[5], 1'h0, serial_port_one_set_ready, 1'h0, dflt_out[5]},
                                  oe_n: {1'h0, 1'h1, 1'h0, 1'h1, dflt_oe_n[5]}};

   // [RULE10] One selector per ball
   genvar g;
   generate
      for (g = 0; g < SPM_NBALL; g++) begin : g_ball
         spm_ball_mux u_mux (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .sel      (sel[g]),
            .src      (src[g]),
            .pad_out  (ball_out[g]),
            .pad_oe_n (ball_oe_n[g])
         );
         assign status_w[g] = (sel[g] != SPM_CODE_DEFAULT);
      end
   endgenerate

   // [RULE8] Pull enables; a set pull-down bit turns the pull into a pull-down.
   assign pd_nxt = pullen_r[SPM_NBALL-1:0] & pulldn_r[SPM_NBALL-1:0];
   assign pu_nxt = pullen_r[SPM_NBALL-1:0] & ~pulldn_r[SPM_NBALL-1:0];

   // Read decode; unmapped addresses read as zero.
   assign rdata_nxt = (req.addr == SPM_ADDR_MUX8)   ? mux8_r :
                      (req.addr == SPM_ADDR_MUX9)   ? mux9_r :
                      (req.addr == SPM_ADDR_MUX10)  ? mux10_r :
                      (req.addr == SPM_ADDR_PULLDN) ? pulldn_r :
                      (req.addr == SPM_ADDR_PULLEN) ? pullen_r :
                      (req.addr == SPM_ADDR_STATUS) ? {26'h0000000, status_w} :
                      32'h00000000;

   // [RULE7] Registers clear so every muxed ball keeps its default function.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mux8_r   <= SPM_MUX_RST;
         mux9_r   <= SPM_MUX_RST;
         mux10_r  <= SPM_MUX_RST;
         pulldn_r <= SPM_PULL_RST;
         pullen_r <= SPM_PULL_RST;
      end else if (req.wr) begin
         if (req.addr == SPM_ADDR_MUX8) begin
            mux8_r <= req.wdata;
         end else if (req.addr == SPM_ADDR_MUX9) begin
            mux9_r <= req.wdata;
         end else if (req.addr == SPM_ADDR_MUX10) begin
            mux10_r <= req.wdata;
         end else if (req.addr == SPM_ADDR_PULLDN) begin
            pulldn_r <= req.wdata;
         end else if (req.addr == SPM_ADDR_PULLEN) begin
            pullen_r <= req.wdata;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata         <= 32'h00000000;
         ball_pull_up_en   <= '0;
         ball_pull_down_en <= '0;
      end else begin
         reg_rdata         <= req.rd ? rdata_nxt : 32'h00000000;
         ball_pull_up_en   <= pu_nxt;
         ball_pull_down_en <= pd_nxt;
      end
   end

   // Ball inputs are asynchronous, so both pass two synchroniser flops and an output flop before use.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_sync_r                     <= 2'h3;
         cts_sync_r                    <= 2'h3;
         serial_port_one_receive       <= 1'h1;
         serial_port_one_clear_to_send <= 1'h1;
      end else begin
         rx_sync_r                     <= {rx_sync_r[0], rx_ball_in};
         cts_sync_r                    <= {cts_sync_r[0], cts_ball_in};
         // [RULE2] Receive always connected
         serial_port_one_receive       <= rx_sync_r[1];
         // [RULE3] Clear-to-send always connected
         serial_port_one_clear_to_send <= cts_sync_r[1];
      end
   end

endmodule

// file: verilog/spm_pkg.sv
// Package for the serial port pin mux: register map, field positions and codes.
package spm_pkg;

   // Register indices on the plain register port (chosen map).
   localparam logic [3:0] SPM_ADDR_MUX8 = 4'h0;
   localparam logic [3:0] SPM_ADDR_MUX9 = 4'h1;
   localparam logic [3:0] SPM_ADDR_MUX10 = 4'h2;
   localparam logic [3:0] SPM_ADDR_PULLDN = 4'h3;
   localparam logic [3:0] SPM_ADDR_PULLEN = 4'h4;
   localparam logic [3:0] SPM_ADDR_STATUS = 4'h5;

   // Reset values.
   localparam logic [31:0] SPM_MUX_RST = 32'h00000000;
   localparam logic [31:0] SPM_PULL_RST = 32'h00000000;

   // Select field low bit positions; every field is three bits wide.
   localparam int SPM_TX_LSB = 21;
   localparam int SPM_RTS_LSB = 12;
   localparam int SPM_DTR_A_LSB = 3;
   localparam int SPM_DTR_B_LSB = 0;
   localparam int SPM_DSR_A_LSB = 0;
   localparam int SPM_DSR_B_LSB = 27;

   // Select codes.
   localparam logic [2:0] SPM_CODE_DEFAULT = 3'h0;
   localparam logic [2:0] SPM_CODE_ALT1 = 3'h1;
   localparam logic [2:0] SPM_CODE_ALT2 = 3'h2;
   localparam logic [2:0] SPM_CODE_ALT3 = 3'h3;
   localparam logic [2:0] SPM_CODE_ALT4 = 3'h4;

   // Number of muxed balls handled here.
   localparam int SPM_NBALL = 6;

   // Ball indices.
   localparam int SPM_BALL_TX = 0;
   localparam int SPM_BALL_RTS = 1;
   localparam int SPM_BALL_DTR_A = 2;
   localparam int SPM_BALL_DTR_B = 3;
   localparam int SPM_BALL_DSR_A = 4;
   localparam int SPM_BALL_DSR_B = 5;

   // Five candidate sources for one ball: default plus four alternates.
   typedef struct packed {
      logic [4:0] out;
      logic [4:0] oe_n;
   } spm_src_t;

   // Register port request.
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } spm_req_t;

endpackage

// file: verilog/spm_ball_mux.sv
// One ball's five-way function selector with registered outputs.
module spm_ball_mux (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // Selection
   input  wire logic [2:0]        sel,
   input  wire spm_pkg::spm_src_t src,
   // Ball drive
   output logic                   pad_out,
   output logic                   pad_oe_n
);

   import spm_pkg::*;

   logic [2:0] idx;

   // [RULE9] Five way choice
   // [RULE10] Unknown codes keep default
   assign idx = (sel <= SPM_CODE_ALT4) ? sel : SPM_CODE_DEFAULT;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pad_out  <= 1'h0;
         pad_oe_n <= 1'h1;
      end else begin
         pad_out  <= src.out[idx];
         pad_oe_n <= src.oe_n[idx];
      end
   end

endmodule

// file: sim/spm_top_assertions.sv
// Assertions on the serial port pin mux ports.
module spm_top_chk (
   // Clock, reset and register writes
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   // Sources, plus the receive and clear-to-send outputs
   input wire logic        serial_port_one_transmit,
   input wire logic        serial_port_one_request_to_send,
   input wire logic        serial_port_one_terminal_ready,
   input wire logic        serial_port_one_set_ready,
   input wire logic        serial_port_one_receive,
   input wire logic        serial_port_one_clear_to_send,
   input wire logic        rx_ball_in,
   input wire logic        cts_ball_in,
   input wire logic [5:0]  dflt_out,
   input wire logic [5:0]  dflt_oe_n,
   input wire logic [5:0]  alt_out,
   // Balls
   input wire logic [5:0]  ball_out,
   input wire logic [5:0]  ball_oe_n,
   input wire logic [5:0]  ball_pull_up_en,
   input wire logic [5:0]  ball_pull_down_en
);
   import spm_pkg::*;

   logic [31:0] m8_r;
   logic [31:0] m9_r;
   logic [31:0] pd_r;
   logic [31:0] pe_r;
   // Shadows of mux eight, mux nine and the pull registers, so checks need no view inside the design.
   always_ff @(posedge core_clk) begin
      m8_r <= !rst_n ? 32'h0 : (reg_wr && reg_addr == SPM_ADDR_MUX8) ? reg_wdata : m8_r;
      m9_r <= !rst_n ? 32'h0 : (reg_wr && reg_addr == SPM_ADDR_MUX9) ? reg_wdata : m9_r;
      pd_r <= !rst_n ? 32'h0 : (reg_wr && reg_addr == SPM_ADDR_PULLDN) ? reg_wdata : pd_r;
      pe_r <= !rst_n ? 32'h0 : (reg_wr && reg_addr == SPM_ADDR_PULLEN) ? reg_wdata : pe_r;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_tx_route: assert property (
      $past(rst_n) && $past(m9_r[23:21]) == 3'h1 |-> ball_out[0] == $past(serial_port_one_transmit) && !ball_oe_n[0])
      else $error("transmit ball wrong");
   a_rts_route: assert property (
      $past(rst_n) && $past(m9_r[14:12]) == 3'h1
      |-> ball_out[1] == $past(serial_port_one_request_to_send) && !ball_oe_n[1])
      else $error("request ball wrong");
   a_dtr_route: assert property (
      $past(rst_n) && $past(m8_r[5:3]) == 3'h2 |-> ball_out[2] == $past(serial_port_one_terminal_ready) && !ball_oe_n[2])
      else $error("terminal ball wrong");
   a_dsr_route: assert property (
      $past(rst_n) && $past(m8_r[2:0]) == 3'h2 |-> ball_out[4] == $past(serial_port_one_set_ready) && !ball_oe_n[4])
      else $error("set ready ball wrong");
   a_alt_route: assert property (
      $past(rst_n) && $past(m9_r[23:21]) == 3'h4 |-> ball_out[0] == $past(alt_out[0]) && !ball_oe_n[0])
      else $error("alternate ball wrong");
   a_dflt_keep: assert property (
      $past(rst_n) && $past(m9_r[23:21]) inside {3'h0, 3'h5, 3'h6, 3'h7}
      |-> ball_out[0] == $past(dflt_out[0]) && ball_oe_n[0] == $past(dflt_oe_n[0]))
      else $error("default ball wrong");
   a_rx_sync: assert property (
      $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |-> serial_port_one_receive == $past(rx_ball_in, 3))
      else $error("receive path wrong");
   a_cts_sync: assert property (
      $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |-> serial_port_one_clear_to_send == $past(cts_ball_in, 3))
      else $error("clear path wrong");
   a_pull_excl: assert property (
      (ball_pull_up_en & ball_pull_down_en) == 6'h0)
      else $error("both pulls on");
   a_pull_follow: assert property (
      $past(rst_n) |-> ball_pull_down_en == ($past(pe_r[5:0]) & $past(pd_r[5:0]))
      && ball_pull_up_en == ($past(pe_r[5:0]) & ~$past(pd_r[5:0])))
      else $error("pull enables wrong");
endmodule

// file: sim/test_spm_top.sv
// Self-checking bench for the serial port pin mux.
module test_spm_top;
   timeunit 1ns;
   timeprecision 100ps;
   import spm_pkg::*;
   logic        core_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic        serial_port_one_transmit = 1'h1, serial_port_one_request_to_send = 1'h0;
   logic        serial_port_one_terminal_ready = 1'h1, serial_port_one_set_ready = 1'h0;
   logic        serial_port_one_receive, serial_port_one_clear_to_send;
   logic        rx_ball_in = 1'h1, cts_ball_in = 1'h1;
   // Defaults differ from the reset drive and from a floating ball, so a lost default shows.
   logic [5:0]  dflt_out = 6'h3F, dflt_oe_n = 6'h15, alt_out = 6'h32;
   logic [5:0]  ball_out, ball_oe_n, ball_pull_up_en, ball_pull_down_en, s;
   logic [1:0]  e;
   int          err_count = 0, n_checks = 0;
   always #12.5 core_clk = ~core_clk;
   spm_top spm_top_i (.*);
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] x);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 chk("rdata", x, reg_rdata);
      @(posedge core_clk);
      #1 chk("rdata_idle", 32'h0, reg_rdata);
   endtask
   task automatic ball(input int i, input logic [1:0] x);
      #1 chk("ball", x, {ball_out[i], ball_oe_n[i]});
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'h1;
      for (int a = 0; a < 6; a++) begin
         rd(4'(a), 32'h0);
      end
      for (int i = 0; i < 6; i++) begin
         ball(i, {dflt_out[i], dflt_oe_n[i]});
      end
      rx_ball_in <= 1'h0;
      cts_ball_in <= 1'h0;
      repeat (2) @(posedge core_clk);
      #1 chk("rx", 1'h1, serial_port_one_receive);
      chk("cts", 1'h1, serial_port_one_clear_to_send);
      @(posedge core_clk);
      #1 chk("rx", 1'h0, serial_port_one_receive);
      chk("cts", 1'h0, serial_port_one_clear_to_send);
      // Every code on the transmit ball; codes 2 and 3 float, codes 5 to 7 keep the default.
      for (int c = 0; c < 8; c++) begin
         wr(SPM_ADDR_MUX9, 32'(c) << SPM_TX_LSB);
         e = c == 1 ? {serial_port_one_transmit, 1'h0} : c == 4 ? {alt_out[0], 1'h0} : c inside {2, 3} ? 2'h1
            : {dflt_out[0], dflt_oe_n[0]};
         ball(0, e);
      end
      wr(SPM_ADDR_MUX9, 32'h10201000);
      wr(SPM_ADDR_MUX8, 32'h00000012);
      wr(SPM_ADDR_MUX10, 32'h00000002);
      rd(SPM_ADDR_MUX9, 32'h10201000);
      rd(SPM_ADDR_STATUS, 32'h0000003F);
      for (int p = 0; p < 2; p++) begin
         s = {{2{serial_port_one_set_ready}}, {2{serial_port_one_terminal_ready}},
              serial_port_one_request_to_send, serial_port_one_transmit};
         for (int i = 0; i < 6; i++) begin
            ball(i, {s[i], 1'h0});
         end
         {serial_port_one_transmit, serial_port_one_request_to_send} <= 2'h1;
         {serial_port_one_terminal_ready, serial_port_one_set_ready} <= 2'h1;
         @(posedge core_clk);
      end
      wr(SPM_ADDR_PULLDN, 32'h00000005);
      wr(SPM_ADDR_PULLEN, 32'h0000000F);
      #1 chk("pull_down", 32'h5, 32'(ball_pull_down_en));
      chk("pull_up", 32'hA, 32'(ball_pull_up_en));
      wr(4'hF, 32'hFFFFFFFF);
      rd(4'hF, 32'h0);
      rd(SPM_ADDR_MUX8, 32'h00000012);
      rst_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'h1;
      rd(SPM_ADDR_MUX9, 32'h0);
      for (int i = 0; i < 6; i++) begin
         ball(i, {dflt_out[i], dflt_oe_n[i]});
      end
      chk("pull_up", 32'h0, 32'(ball_pull_up_en));
      chk("pull_down", 32'h0, 32'(ball_pull_down_en));
      end_sim();
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      end_sim();
   end
endmodule
bind spm_top spm_top_chk spm_top_chk_i (.*);
